//--- src/hb_ctrl_cfg.svh
// Constants for the half-bridge control register bank
`ifndef HB_CTRL_CFG_SVH
`define HB_CTRL_CFG_SVH

`define FRAME_BITS        16
`define FRAME_CNT_W       4
`define FRAME_CNT_LAST    4'hf
`define OP_BIT            7
`define LAST_ADDRESS_BIT_TOKEN_BIT          1
`define ADDR_LSB          2
`define ADDR_MSB          6
`define MARK_BIT          0
`define ADDR_ACT_LOW      5'h00
`define ADDR_CONFIG       5'h13
`define CONFIG_RST        8'h02
`define CTRL_RST          8'h00
`define BRIDGES           4

`endif

//--- src/hb_ctrl_pkg.sv
// Types shared by the half-bridge control register bank
package hb_ctrl_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ADDR = 2'b01,
		ST_DATA = 2'b11
	} frame_state_t;
	typedef logic [7:0] reg_byte_t;
endpackage

//--- src/spi_frame_rx.sv
// Serial frame shifter: collects a 16-bit frame and shifts out the answer byte
`timescale 1ns/1ps
`default_nettype none
`include "hb_ctrl_cfg.svh"

module spi_frame_rx (
	input  wire logic                 clk,
	input  wire logic                 resetn,
	input  wire logic                 cs_n,
	input  wire logic                 sclk_rise,
	input  wire logic                 sclk_fall,
	input  wire logic                 mosi,
	input  wire hb_ctrl_pkg::reg_byte_t reply,
	output var  logic                 miso_out,
	output var  logic                 miso_oe_n,
	output var  logic                 frame_done,
	output var  logic [15:0]          frame_ff
);
	import hb_ctrl_pkg::*;

	logic [`FRAME_CNT_W-1:0] cnt_ff;
	logic                    full_ff;
	logic [7:0]              tx_ff;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_ff  <= '0;
			full_ff <= 1'b0;
			frame_ff <= '0;
		end else if (cs_n) begin
			cnt_ff  <= '0;
			full_ff <= 1'b0;
		end else if (sclk_rise && !full_ff) begin
			frame_ff <= {frame_ff[14:0], mosi}; // RULE_04
			cnt_ff   <= cnt_ff + 1'b1;
			if (cnt_ff == `FRAME_CNT_LAST)
				full_ff <= 1'b1;
		end
	end

	// Commit only on chip-select release after at least 16 bits; bits after the 16th are ignored
	assign frame_done = cs_n && full_ff; // RULE_13

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tx_ff    <= '0;
			miso_out <= 1'b0;
		end else if (cs_n) begin
			tx_ff    <= reply;
			miso_out <= 1'b0;
		end else if (sclk_fall) begin
			miso_out <= tx_ff[7];
			tx_ff    <= {tx_ff[6:0], 1'b0};
		end
	end

	assign miso_oe_n = cs_n;
endmodule // spi_frame_rx

`default_nettype wire

//--- src/bridge_interlock.sv
// Cross-current interlock for one group of half-bridges
`timescale 1ns/1ps
`default_nettype none
`include "hb_ctrl_cfg.svh"

module bridge_interlock (
	input  wire logic [7:0]          enables,
	output var  logic [`BRIDGES-1:0] upper_on,
	output var  logic [`BRIDGES-1:0] lower_on
);
	import hb_ctrl_pkg::*;

	genvar i;
	generate
		for (i = 0; i < `BRIDGES; i++) begin : g_br
			// Both requested means bridge fully off, whatever software wrote
			assign lower_on[i] = enables[2*i] & ~enables[2*i+1];  // RULE_09 RULE_11 RULE_12
			assign upper_on[i] = enables[2*i+1] & ~enables[2*i];  // RULE_10 RULE_11
		end
	endgenerate
endmodule // bridge_interlock

`default_nettype wire

//--- src/hb_ctrl_regs.sv
// Half-bridge control register bank behind a 16-bit serial frame port
//
// Behaviour
// RULE_01: Every control register readable and writable serially
// RULE_02: Control registers reset to all zeros
// RULE_03: Configuration register resets to 0000 0010
// RULE_04: Frame is address byte, then data byte
// RULE_05: Device never alters control bits itself
// RULE_06: Frame bit 7 low reads, no change
// RULE_07: Frame bit 7 high writes data byte
// RULE_08: Address 000 00 selects bridges 1-4 enables
// RULE_09: Bridge n: low bit 2(n-1), high next
// RULE_10: Zero keeps switch off, one turns on
// RULE_11: Both enables set turns bridge off
// RULE_12: Interlock done in logic, independent of software
// RULE_13: Only complete 16-bit frames update registers
`timescale 1ns/1ps
`default_nettype none
`include "hb_ctrl_cfg.svh"

module hb_ctrl_regs (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        cs_n,
	input  wire logic        sclk,
	input  wire logic        mosi,
	output var  logic        miso_out,
	output var  logic        miso_oe_n,
	output var  logic [3:0]  upper_switch_on,
	output var  logic [3:0]  lower_switch_on,
	output var  logic [7:0]  config_value,
	output var  logic        addr_error
);
	import hb_ctrl_pkg::*;

	////////////////////////////////////////////////////////////////////////////////

	logic        sclk_ff;
	logic        sclk_rise;
	logic        sclk_fall;
	logic        frame_done;
	logic [15:0] frame;
	logic [7:0]  addr_byte;
	logic [7:0]  data_byte;
	logic [4:0]  addr;
	logic        hit_act;
	logic        hit_cfg;
	logic        valid_addr;
	reg_byte_t   bridge_switch_enable_low_ff;
	reg_byte_t   config_ff;
	reg_byte_t   reply;

	// Serial clock is sampled; it must stay well below the system clock rate
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			sclk_ff <= 1'b0;
		else
			sclk_ff <= sclk;
	end

	assign sclk_rise = sclk & ~sclk_ff;
	assign sclk_fall = ~sclk & sclk_ff;

	spi_frame_rx u_rx (
		.clk        (clk),
		.resetn     (resetn),
		.cs_n       (cs_n),
		.sclk_rise  (sclk_rise),
		.sclk_fall  (sclk_fall),
		.mosi       (mosi),
		.reply      (reply),
		.miso_out   (miso_out),
		.miso_oe_n  (miso_oe_n),
		.frame_done (frame_done),
		.frame_ff   (frame)
	);

	////////////////////////////////////////////////////////////////////////////////

	assign addr_byte = frame[15:8]; // RULE_04
	assign data_byte = frame[7:0];
	assign addr      = addr_byte[`ADDR_MSB:`ADDR_LSB];

	// Last-address-bit token is ignored; final bit must be 1
	always_comb begin
		hit_act = 1'b0;
		hit_cfg = 1'b0;
		if (addr_byte[`MARK_BIT] && addr == `ADDR_ACT_LOW)
			hit_act = 1'b1; // RULE_08
		else if (addr_byte[`MARK_BIT] && addr == `ADDR_CONFIG)
			hit_cfg = 1'b1;
	end

	assign valid_addr = hit_act | hit_cfg;

	// Registers change only on a host write frame, never on their own
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			bridge_switch_enable_low_ff <= `CTRL_RST; // RULE_02
		else if (frame_done && addr_byte[`OP_BIT] && hit_act)
			bridge_switch_enable_low_ff <= data_byte; // RULE_07 RULE_05 RULE_01
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			config_ff <= `CONFIG_RST; // RULE_03
		else if (frame_done && addr_byte[`OP_BIT] && hit_cfg)
			config_ff <= data_byte; // RULE_07 RULE_05
	end

	// Answer for the next frame: content of the register the last frame addressed, zero if that address was unknown
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			reply <= `CTRL_RST;
		else if (frame_done && hit_act)
			reply <= addr_byte[`OP_BIT] ? data_byte : bridge_switch_enable_low_ff; // RULE_06
		else if (frame_done && hit_cfg)
			reply <= addr_byte[`OP_BIT] ? data_byte : config_ff; // RULE_06 RULE_01
		else if (frame_done)
			reply <= `CTRL_RST;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			addr_error <= 1'b0;
		else if (frame_done)
			addr_error <= ~valid_addr;
	end

	assign config_value = config_ff;

	////////////////////////////////////////////////////////////////////////////////

	bridge_interlock u_lock (
		.enables  (bridge_switch_enable_low_ff),
		.upper_on (upper_switch_on),
		.lower_on (lower_switch_on)
	);
endmodule // hb_ctrl_regs

`default_nettype wire

//--- verif/bank_monitor.sv
// Assertion checker for the bridge enable register bank
`timescale 1ns/1ps
`default_nettype none
module bank_monitor (
	input wire logic       clk,
	input wire logic       resetn,
	input wire logic       cs_n,
	input wire logic       miso_oe_n,
	input wire logic [3:0] upper_switch_on,
	input wire logic [3:0] lower_switch_on,
	input wire logic [7:0] config_value,
	input wire logic       addr_error
);
	wire logic [7:0] sw = {upper_switch_on, lower_switch_on};
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// Commit lands a cycle late, so three low samples are quiet
	sequence s_busy; !cs_n [*3]; endsequence
	sequence s_idle; cs_n [*4]; endsequence
	a_no_cross: assert property ((upper_switch_on & lower_switch_on) == 4'h0)
		else $error("both switches on");
	a_reset_cfg: assert property ($rose(resetn) |-> config_value == 8'h02)
		else $error("config reset");
	a_reset_sw: assert property ($rose(resetn) |-> sw == 8'h00)
		else $error("switch reset");
	a_frame_hold: assert property (s_busy |-> $stable({sw, config_value}))
		else $error("change in frame");
	a_idle_hold: assert property (s_idle |-> $stable({sw, config_value}))
		else $error("change in idle");
	a_sw_at_end: assert property ($changed(sw) |-> cs_n || $past(cs_n))
		else $error("switch change");
	a_cfg_at_end: assert property ($changed(config_value) |-> cs_n || $past(cs_n))
		else $error("config change");
	a_err_at_end: assert property ($changed(addr_error) |-> cs_n || $past(cs_n))
		else $error("error change");
	a_oe_follows: assert property (miso_oe_n == cs_n)
		else $error("miso enable");
endmodule // bank_monitor
`default_nettype wire

//--- verif/spi_host_model.sv
// Serial master standing in for the host controller
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	input  wire logic        clk,
	input  wire logic        miso_out,
	output var  logic        cs_n,
	output var  logic        sclk,
	output var  logic        mosi,
	output var  logic [15:0] rx
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
		rx = 16'h0000;
	end
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic xfer(input logic [15:0] f, input int n);
		tick(1);
		cs_n = 1'b0;
		for (int i = 15; i > 15 - n; i--) begin
			mosi = f[i];
			tick(4);
			rx = {rx[14:0], miso_out};
			sclk = 1'b1;
			tick(3);
			sclk = 1'b0;
		end
		tick(3);
		cs_n = 1'b1;
		// Released line flips so a stale level is never trusted
		mosi = ~mosi;
		tick(4);
	endtask
endmodule // spi_host_model
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the bridge enable register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clk, resetn, cs_n, sclk, mosi, miso_out, miso_oe_n, addr_error;
	logic [3:0]  upper_switch_on, lower_switch_on;
	logic [7:0]  config_value;
	logic [15:0] rx;
	int          err_count, num_checks;
	logic [7:0]  vals [5] = '{8'h05, 8'h03, 8'hc0, 8'hff, 8'h5a};
	wire logic [7:0] sw = {upper_switch_on, lower_switch_on};
	hb_ctrl_regs dut (.clk, .resetn, .cs_n, .sclk, .mosi, .miso_out, .miso_oe_n,
		.upper_switch_on, .lower_switch_on, .config_value, .addr_error);
	spi_host_model host (.clk, .miso_out, .cs_n, .sclk, .mosi, .rx);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		repeat (100000) @(posedge clk);
		err_count++;
		results();
	end
	task automatic check(input string nm, input logic [7:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// A bridge asked for both switches stays fully off
	function automatic logic [7:0] drive(input logic [7:0] r);
		logic [7:0] s;
		s = 8'h00;
		for (int n = 0; n < 4; n++)
			if (r[2*n] != r[2*n+1]) begin
				s[n+4] = r[2*n+1];
				s[n] = r[2*n];
			end
		return s;
	endfunction
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		resetn = 1'b0;
		repeat (16) @(posedge clk);
		#1;
		resetn = 1'b1;
		host.tick(2);
		check("config", config_value, 8'h02);
		check("switches", sw, 8'h00);
		check("oe idle", {7'h00, miso_oe_n}, 8'h01);
		foreach (vals[i]) begin
			host.xfer({8'h81, vals[i]}, 16);
			check("switches", sw, drive(vals[i]));
		end
		host.xfer(16'h0100, 16);
		// Data byte of a read is ignored; the answer byte lands one sample late
		host.xfer(16'h0181, 16);
		check("read", rx[14:7], 8'h5a);
		// A cut frame would write 0x33 to the enables if it were committed
		host.xfer(16'h3300, 8);
		host.xfer(16'h8533, 16);
		check("error", {7'h00, addr_error}, 8'h01);
		check("switches", sw, drive(8'h5a));
		host.xfer(16'hcd07, 16);
		check("config", config_value, 8'h07);
		check("error", {7'h00, addr_error}, 8'h00);
		host.xfer(16'h4d00, 16);
		host.xfer(16'h4d00, 16);
		check("read config", rx[14:7], 8'h07);
		check("config", config_value, 8'h07);
		resetn = 1'b0;
		host.tick(2);
		resetn = 1'b1;
		host.tick(2);
		check("config", config_value, 8'h02);
		check("switches", sw, 8'h00);
		results();
	end
endmodule // testbench
bind hb_ctrl_regs bank_monitor mon (.clk, .resetn, .cs_n, .miso_oe_n, .upper_switch_on,
	.lower_switch_on, .config_value, .addr_error);
`default_nettype wire
